/* pkg/cca_pkg.sv */
// constants, command codes, status words and types of the card channel access block
// assumes: one clock, commands already framed into bytes by the card link logic
package cca_pkg;

	// ****************************************
	// sizes
	// ****************************************
	localparam int NUM_CH = 4;
	localparam int CH_W = 2;
	localparam int REC_W = 8;

	// ****************************************
	// class and instruction codes
	// ****************************************
	localparam logic [7:0] CLA_GSM = 8'ha0;
	localparam logic [7:0] INS_SELECT = 8'ha4;
	localparam logic [7:0] INS_STATUS = 8'hf2;
	localparam logic [7:0] INS_GETRSP = 8'hc0;
	localparam logic [7:0] INS_MANAGE = 8'h70;
	localparam logic [7:0] INS_RDREC = 8'hb2;
	localparam logic [7:0] INS_UPREC = 8'hdc;
	localparam logic [7:0] INS_CREATE = 8'he0;
	localparam logic [7:0] P1_OPEN = 8'h00;
	localparam logic [7:0] P1_CLOSE = 8'h80;
	localparam logic [7:0] P1_BY_NAME = 8'h04;
	localparam logic [7:0] REC_NEXT = 8'h00;

	// ****************************************
	// two-byte status words
	// ****************************************
	localparam logic [15:0] SW_OK = 16'h9000;
	localparam logic [15:0] SW_CLA_NS = 16'h6e00;
	localparam logic [15:0] SW_CH_NS = 16'h6881;
	localparam logic [15:0] SW_SEC = 16'h6982;
	localparam logic [15:0] SW_COND = 16'h6985;
	localparam logic [15:0] SW_NOT_ALLOWED = 16'h6986;
	localparam logic [15:0] SW_NO_CHAN = 16'h6a81;
	localparam logic [15:0] SW_NOT_FOUND = 16'h6a82;
	localparam logic [15:0] SW_BAD_P = 16'h6a86;
	localparam logic [15:0] SW_EXISTS = 16'h6a89;

	// ****************************************
	// file identifiers
	// ****************************************
	localparam logic [15:0] FID_MF = 16'h3f00;
	localparam logic [15:0] FID_CUR_APP = 16'h7fff;
	localparam logic [15:0] FID_TELECOM = 16'h7f10;
	localparam logic [15:0] FID_DIR = 16'h2f00;
	localparam logic [15:0] FID_ATR = 16'h2f01;
	localparam logic [15:0] FID_2F05 = 16'h2f05;
	localparam logic [15:0] FID_2F06 = 16'h2f06;
	localparam logic [15:0] FID_NIB_MASK = 16'hfff0;
	localparam logic [15:0] FID_GRP_7F4 = 16'h7f40;
	localparam logic [15:0] FID_GRP_5F1 = 16'h5f10;
	localparam logic [15:0] FID_GRP_5F2 = 16'h5f20;
	localparam logic [15:0] FID_GRP_7F2 = 16'h7f20;
	localparam logic [15:0] FID_GRP_2F1 = 16'h2f10;
	localparam logic [15:0] FID_GRP_2FE = 16'h2fe0;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [2:0] {
		OP_NONE = 3'b000,
		OP_OPEN = 3'b001,
		OP_CLOSE = 3'b010,
		OP_SEL_DF = 3'b011,
		OP_SEL_EF = 3'b100,
		OP_SEL_ADF = 3'b101,
		OP_END_APP = 3'b110,
		OP_REC = 3'b111
	} cca_op_e;

	typedef enum logic [1:0] {
		SC_ALW = 2'b00,
		SC_L1 = 2'b01,
		SC_L2 = 2'b10,
		SC_NEV = 2'b11
	} cca_sc_e;

	typedef enum logic [1:0] {
		FMT_COMPACT = 2'b00,
		FMT_EXPANDED = 2'b01,
		FMT_REFERENCED = 2'b10,
		FMT_NONE = 2'b11
	} cca_fmt_e;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_EVAL = 2'b01,
		ST_RESP = 2'b10
	} cca_state_e;

	// identifiers that may never be given to a new file
	function automatic logic cca_fid_reserved(input logic [15:0] fid);
		logic [15:0] grp;
		grp = fid & FID_NIB_MASK;
		return (fid == FID_CUR_APP) || (fid == FID_TELECOM) || (fid == FID_DIR) ||
			(fid == FID_ATR) || (fid == FID_2F05) || (fid == FID_2F06) ||
			(grp == FID_GRP_7F4) || (grp == FID_GRP_5F1) || (grp == FID_GRP_5F2) ||
			(grp == FID_GRP_7F2) || (grp == FID_GRP_2F1) || (grp == FID_GRP_2FE);
	endfunction

endpackage

/* pkg/cca_tbl_if.sv */
// carrier between the command decoder and the per-channel state table
// assumes: writes come one at a time from the decoder's evaluation cycle
`timescale 1ns/1ns
interface cca_tbl_if;
	import cca_pkg::*;
	logic wr;
	cca_op_e op;
	logic [CH_W-1:0] ch;
	logic [CH_W-1:0] src;
	logic [CH_W-1:0] rd_ch;
	logic [15:0] fid;
	logic usim;
	logic [REC_W-1:0] rec;
	logic [15:0] q_fid;
	logic [15:0] cur_df;
	logic [15:0] cur_ef;
	logic [15:0] adf;
	logic ef_valid;
	logic adf_valid;
	logic [REC_W-1:0] rec_ptr;
	logic [NUM_CH-1:0] open_vec;
	logic [NUM_CH-1:0] usim_vec;
	logic q_hit;
	modport ctl(output wr, op, ch, src, rd_ch, fid, usim, rec, q_fid,
		input cur_df, cur_ef, adf, ef_valid, adf_valid, rec_ptr, open_vec, usim_vec, q_hit);
	modport tbl(input wr, op, ch, src, rd_ch, fid, usim, rec, q_fid,
		output cur_df, cur_ef, adf, ef_valid, adf_valid, rec_ptr, open_vec, usim_vec, q_hit);
endinterface

/* hdl/cca_chan_table.sv */
// per-channel selection state: open flag, current directory, file, application, record
// assumes: decoder drives one write per command; reset stands for card deactivation
`timescale 1ns/1ns
module cca_chan_table (
	input wire logic i_clk,
	input wire logic i_rst_n,
	cca_tbl_if.tbl t
);
	import cca_pkg::*;

	logic [15:0] df_all [NUM_CH];
	logic [15:0] ef_all [NUM_CH];
	logic [15:0] adf_all [NUM_CH];
	logic [REC_W-1:0] rec_all [NUM_CH];
	logic [NUM_CH-1:0] efv_all;
	logic [NUM_CH-1:0] adfv_all;
	logic [NUM_CH-1:0] hit_vec;

	// ****************************************
	// one state slot per channel
	// ****************************************
	genvar g;
	generate
	for (g = 0; g < NUM_CH; g++) begin : gen_ch
		logic [15:0] df_ff;
		logic [15:0] ef_ff;
		logic [15:0] adf_ff;
		logic [REC_W-1:0] rec_ff;
		logic efv_ff;
		logic adfv_ff;
		logic open_ff;
		logic usim_ff;
		wire sel = t.wr && (t.ch == CH_W'(g));
		wire from_basic = (t.src == '0);

		// each slot only ever changes on its own writes, so channels never disturb each other
		always_ff @(posedge i_clk) begin
			if (!i_rst_n) begin
				df_ff <= FID_MF;
				ef_ff <= '0;
				adf_ff <= '0;
				rec_ff <= '0;
				efv_ff <= 1'b0;
				adfv_ff <= 1'b0;
				open_ff <= (g == 0);
				usim_ff <= 1'b0;
			end else if (sel) begin
				case (t.op)
				OP_OPEN: begin
					open_ff <= 1'b1;
					df_ff <= from_basic ? FID_MF : df_all[t.src];
					adf_ff <= adf_all[t.src];
					adfv_ff <= !from_basic && adfv_all[t.src];
					efv_ff <= 1'b0;
					rec_ff <= '0;
					usim_ff <= 1'b0;
				end
				OP_CLOSE: begin
					// basic channel stays open whatever is asked
					open_ff <= (g == 0);
					usim_ff <= 1'b0;
					adfv_ff <= 1'b0;
					efv_ff <= 1'b0;
				end
				OP_SEL_DF: begin
					df_ff <= t.fid;
					efv_ff <= 1'b0;
				end
				OP_SEL_EF: begin
					ef_ff <= t.fid;
					efv_ff <= 1'b1;
					rec_ff <= '0;
				end
				OP_SEL_ADF: begin
					adf_ff <= t.fid;
					df_ff <= t.fid;
					adfv_ff <= 1'b1;
					efv_ff <= 1'b0;
					usim_ff <= t.usim;
				end
				OP_END_APP: begin
					adfv_ff <= 1'b0;
					usim_ff <= 1'b0;
				end
				OP_REC: rec_ff <= t.rec;
				default: open_ff <= open_ff;
				endcase
			end
		end

		// another open channel already holds the queried file as current
		assign hit_vec[g] = open_ff && (t.rd_ch != CH_W'(g)) &&
			((efv_ff && ef_ff == t.q_fid) || df_ff == t.q_fid);
		assign df_all[g] = df_ff;
		assign ef_all[g] = ef_ff;
		assign adf_all[g] = adf_ff;
		assign rec_all[g] = rec_ff;
		assign efv_all[g] = efv_ff;
		assign adfv_all[g] = adfv_ff;
		assign t.open_vec[g] = open_ff;
		assign t.usim_vec[g] = usim_ff;
	end
	endgenerate

	// ****************************************
	// read side for the channel being served
	// ****************************************
	assign t.cur_df = df_all[t.rd_ch];
	assign t.cur_ef = ef_all[t.rd_ch];
	assign t.adf = adf_all[t.rd_ch];
	assign t.rec_ptr = rec_all[t.rd_ch];
	assign t.ef_valid = efv_all[t.rd_ch];
	assign t.adf_valid = adfv_all[t.rd_ch];
	assign t.q_hit = |hit_vec;

endmodule

/* hdl/cca_access_ctl.sv */
// command gate of the card: session exclusion, channel management, access check
// assumes: file system decodes descriptors and access rules, feeds flags with each command
`timescale 1ns/1ns

module cca_access_ctl #(
	parameter bit MULTI_VERIF = 1'b1
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_cmd_valid,
	output logic o_cmd_ready,
	input wire logic [7:0] i_cla,
	input wire logic [7:0] i_ins,
	input wire logic [7:0] i_p1,
	input wire logic [7:0] i_p2,
	input wire logic [15:0] i_fid,
	input wire logic i_is_df,
	input wire logic i_file_shareable,
	input wire logic i_cur_df_shareable,
	input wire logic i_app_activate,
	input wire logic i_app_usim,
	input wire cca_pkg::cca_sc_e i_sc_need,
	input wire cca_pkg::cca_fmt_e i_sc_fmt,
	input wire logic i_sc_known,
	input wire logic i_ver_l1,
	input wire logic i_ver_l2,
	input wire logic i_ver_univ,
	output logic o_rsp_valid,
	input wire logic i_rsp_ready,
	output logic [15:0] o_sw,
	output logic [7:0] o_rsp_data,
	output logic o_exec,
	output logic [cca_pkg::NUM_CH-1:0] o_chan_open,
	output logic o_usim_active,
	output logic o_gsm_active,
	output logic [15:0] o_cur_df,
	output logic [15:0] o_cur_ef,
	output logic o_ef_valid,
	output logic [cca_pkg::REC_W-1:0] o_rec_ptr
);
	import cca_pkg::*;

	// ****************************************
	// state and latched command
	// ****************************************
	cca_state_e st_ff;
	cca_state_e nxt_st;
	logic [7:0] cla_ff;
	logic [7:0] ins_ff;
	logic [7:0] p1_ff;
	logic [7:0] p2_ff;
	logic [15:0] fid_ff;
	logic is_df_ff;
	logic shr_ff;
	logic df_shr_ff;
	logic act_ff;
	logic app_usim_ff;
	cca_sc_e need_ff;
	cca_fmt_e fmt_ff;
	logic known_ff;
	logic l1_ff;
	logic l2_ff;
	logic univ_ff;
	logic [15:0] sw_ff;
	logic [7:0] data_ff;
	logic exec_ff;
	logic gsm_ff;

	cca_tbl_if tbl();

	cca_chan_table u_tbl (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.t(tbl)
	);

	// lowest closed channel, used when the card assigns a number itself
	function automatic logic [CH_W-1:0] first_free(input logic [NUM_CH-1:0] open_v);
		logic [CH_W-1:0] idx;
		idx = '0;
		for (int k = NUM_CH - 1; k > 0; k--) begin
			if (!open_v[k]) begin
				idx = CH_W'(k);
			end
		end
		return idx;
	endfunction

	// ****************************************
	// command decode
	// ****************************************
	wire [CH_W-1:0] ch = cla_ff[CH_W-1:0];
	wire [NUM_CH-1:0] ch_bit = NUM_CH'(1) << ch;
	wire is_gsm = (cla_ff == CLA_GSM);
	wire usim_any = |tbl.usim_vec;
	wire usim_other = |(tbl.usim_vec & ~ch_bit);
	wire chan_ok = tbl.open_vec[ch];
	wire is_sel = (ins_ff == INS_SELECT);
	wire is_mgr = (ins_ff == INS_MANAGE);
	wire is_rec = (ins_ff == INS_RDREC) || (ins_ff == INS_UPREC);
	wire is_create = (ins_ff == INS_CREATE);
	wire no_gate = (ins_ff == INS_STATUS) || (ins_ff == INS_GETRSP);
	wire by_name = (p1_ff == P1_BY_NAME);
	wire cur_app = (fid_ff == FID_CUR_APP);
	wire mg_open = (p1_ff == P1_OPEN);
	wire mg_close = (p1_ff == P1_CLOSE);
	wire free_any = ~&tbl.open_vec;
	wire [CH_W-1:0] free_ch = first_free(tbl.open_vec);
	wire [CH_W-1:0] cl_ch = p2_ff[CH_W-1:0];
	wire cl_bad = (p2_ff >= 8'(NUM_CH)) || (cl_ch == '0) || !tbl.open_vec[cl_ch];

	// access gate: level-1 may be met by the universal code only on multi cards
	wire l1_ok = MULTI_VERIF ? (l1_ff || univ_ff) : l1_ff;
	wire fmt_ok = (fmt_ff != FMT_NONE) && (MULTI_VERIF || fmt_ff != FMT_REFERENCED);
	wire cond_known = known_ff && fmt_ok;
	wire cond_met = (need_ff == SC_ALW) || (need_ff == SC_L1 && l1_ok) ||
		(need_ff == SC_L2 && l2_ff);
	wire [15:0] sec_sw = (!cond_known || !cond_met) ? SW_SEC : SW_OK;

	// manage channel answers
	wire [15:0] open_sw = !df_shr_ff ? SW_NOT_ALLOWED : (!free_any ? SW_NO_CHAN : SW_OK);
	wire [15:0] mg_sw = mg_open ? open_sw : (mg_close && !cl_bad) ? SW_OK : SW_BAD_P;

	// select answers: exclusion of sessions, implicit application, sharing
	wire usim_block = act_ff && app_usim_ff && (gsm_ff || usim_other);
	wire [15:0] name_sw = usim_block ? SW_COND : SW_OK;
	wire [15:0] fid_sw = cur_app ? (tbl.adf_valid ? SW_OK : SW_NOT_FOUND) :
		(!shr_ff && tbl.q_hit) ? SW_COND : SW_OK;
	wire [15:0] sel_sw = by_name ? name_sw : fid_sw;

	// final status, highest priority first
	wire [15:0] eval_sw = (is_gsm && usim_any) ? SW_CLA_NS :
		!chan_ok ? SW_CH_NS :
		is_mgr ? mg_sw :
		is_sel ? sel_sw :
		(is_create && cca_fid_reserved(fid_ff)) ? SW_EXISTS :
		no_gate ? SW_OK :
		sec_sw;
	wire eval_ok = (st_ff == ST_EVAL) && (eval_sw == SW_OK);

	// ****************************************
	// table write selection
	// ****************************************
	wire [REC_W-1:0] rec_next = (p1_ff == REC_NEXT) ? tbl.rec_ptr + REC_W'(1) : p1_ff[REC_W-1:0];
	wire cl_app = by_name && !act_ff;
	cca_op_e sel_op;
	cca_op_e mg_op;
	cca_op_e wr_op;
	assign sel_op = by_name ? (act_ff ? OP_SEL_ADF : OP_END_APP) :
		(cur_app || is_df_ff) ? OP_SEL_DF : OP_SEL_EF;
	assign mg_op = mg_open ? OP_OPEN : OP_CLOSE;
	assign wr_op = is_mgr ? mg_op : is_sel ? sel_op : is_rec ? OP_REC : OP_NONE;

	assign tbl.wr = eval_ok && (wr_op != OP_NONE);
	assign tbl.op = wr_op;
	assign tbl.ch = !is_mgr ? ch : (mg_open ? free_ch : cl_ch);
	assign tbl.src = ch;
	assign tbl.rd_ch = ch;
	assign tbl.fid = (cur_app && !by_name) ? tbl.adf : fid_ff;
	assign tbl.usim = app_usim_ff;
	assign tbl.rec = rec_next;
	assign tbl.q_fid = fid_ff;

	// ****************************************
	// sequencing: one command in flight
	// ****************************************
	always_comb begin
		case (st_ff)
		ST_IDLE: nxt_st = i_cmd_valid ? ST_EVAL : ST_IDLE;
		ST_EVAL: nxt_st = ST_RESP;
		ST_RESP: nxt_st = i_rsp_ready ? ST_IDLE : ST_RESP;
		default: nxt_st = ST_IDLE;
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			st_ff <= ST_IDLE;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// command fields captured once, so late changes on the inputs cannot leak in
	always_ff @(posedge i_clk) begin
		if (o_cmd_ready && i_cmd_valid) begin
			{cla_ff, ins_ff, p1_ff, p2_ff} <= {i_cla, i_ins, i_p1, i_p2};
			{fid_ff, is_df_ff, shr_ff, df_shr_ff} <= {i_fid, i_is_df, i_file_shareable, i_cur_df_shareable};
			{act_ff, app_usim_ff, known_ff} <= {i_app_activate, i_app_usim, i_sc_known};
			{l1_ff, l2_ff, univ_ff} <= {i_ver_l1, i_ver_l2, i_ver_univ};
			need_ff <= i_sc_need;
			fmt_ff <= i_sc_fmt;
		end
	end

	// answer registers and the gsm session flag
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			sw_ff <= SW_OK;
			data_ff <= '0;
			exec_ff <= 1'b0;
			gsm_ff <= 1'b0;
		end else begin
			exec_ff <= eval_ok && !is_mgr && !cl_app;
			if (st_ff == ST_EVAL) begin
				sw_ff <= eval_sw;
				data_ff <= (is_mgr && mg_open && eval_ok) ? 8'(free_ch) : '0;
			end
			if (eval_ok && is_gsm) begin
				gsm_ff <= 1'b1;
			end
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign o_cmd_ready = (st_ff == ST_IDLE);
	assign o_rsp_valid = (st_ff == ST_RESP);
	assign o_sw = sw_ff;
	assign o_rsp_data = data_ff;
	assign o_exec = exec_ff;
	assign o_chan_open = tbl.open_vec;
	assign o_usim_active = usim_any;
	assign o_gsm_active = gsm_ff;
	assign o_cur_df = tbl.cur_df;
	assign o_cur_ef = tbl.cur_ef;
	assign o_ef_valid = tbl.ef_valid;
	assign o_rec_ptr = tbl.rec_ptr;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_n);

	sequence s_take;
		o_cmd_ready && i_cmd_valid;
	endsequence
	sequence s_answer;
		(st_ff == ST_EVAL) ##1 (o_rsp_valid && !o_cmd_ready);
	endsequence

	a_gsm_class_reject: assert property (
		(st_ff == ST_EVAL && is_gsm && usim_any) |=> (o_sw == SW_CLA_NS && o_rsp_valid && !o_exec))
		else $error("gsm class not rejected during usim session");
	a_session_excl: assert property (!(gsm_ff && o_usim_active))
		else $error("gsm and usim sessions both active");
	a_one_usim: assert property ($onehot0(tbl.usim_vec))
		else $error("more than one usim session");
	a_reserved_fid: assert property (
		(st_ff == ST_EVAL && chan_ok && is_create && !(is_gsm && usim_any) &&
		cca_fid_reserved(fid_ff)) |=> (o_sw == SW_EXISTS && !o_exec))
		else $error("reserved identifier accepted");
	a_basic_open: assert property (o_chan_open[0])
		else $error("basic channel closed");
	a_single_cmd: assert property (s_take |=> s_answer)
		else $error("command not answered alone");
	a_open_number: assert property (
		(eval_ok && is_mgr && mg_open) |=> (o_sw == SW_OK &&
		((o_chan_open & ~$past(o_chan_open)) == (NUM_CH'(1) << o_rsp_data[CH_W-1:0]))))
		else $error("opened channel number wrong");
	a_close_only: assert property (
		(|($past(o_chan_open) & ~o_chan_open)) |-> $past(tbl.wr && tbl.op == OP_CLOSE))
		else $error("channel closed without command");
	a_noshare_open: assert property (
		(st_ff == ST_EVAL && chan_ok && is_mgr && mg_open && !df_shr_ff && !(is_gsm && usim_any))
		|=> (o_sw == SW_NOT_ALLOWED && $stable(o_chan_open)))
		else $error("open from unshareable directory");
	a_sec_unknown: assert property (
		(st_ff == ST_EVAL && chan_ok && is_rec && !cond_known && !(is_gsm && usim_any))
		|=> (o_sw == SW_SEC && !o_exec))
		else $error("unknown access condition granted");

endmodule

/* tb/cca_term_model.sv */
// terminal model: offers class-coded commands one at a time, takes responses slow or prompt
// assumes: card takes a command at a rising edge with ready high; seed set by the bench
`timescale 1ns/1ns
module cca_term_model (
	input wire logic i_clk,
	input wire logic i_cmd_ready,
	input wire logic i_rsp_valid,
	output logic o_cmd_valid,
	output logic [7:0] o_cla,
	output logic [7:0] o_ins,
	output logic [7:0] o_p1,
	output logic [7:0] o_p2,
	output logic [15:0] o_fid,
	output logic [11:0] o_f,
	output logic o_rsp_ready
);
	// ****************************************
	// command offer and response acceptance
	// ****************************************
	logic [23:0] exp_q[$];
	logic [1:0] dly = 2'h0;
	initial begin
		o_cmd_valid = 1'b0;
		{o_cla, o_ins, o_p1, o_p2, o_fid, o_f} = '0;
		o_rsp_ready = 1'b0;
	end
	// channel rides in the low class bits; the expected answer is noted at offer time
	task automatic cmd(input logic [7:0] cla, ins, p1, p2, input logic [15:0] fid,
		input logic [11:0] f, input logic [15:0] sw, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge i_clk);
		o_cmd_valid <= 1'b1;
		{o_cla, o_ins, o_p1, o_p2, o_fid, o_f} <= {cla, ins, p1, p2, fid, f};
		exp_q.push_back({sw, d});
		// ready is settled at the falling edge, so the take edge is known without a race
		do begin
			@(negedge i_clk);
			n++;
		end while (!i_cmd_ready && n < 50);
		@(posedge i_clk);
		o_cmd_valid <= 1'b0;
		// released command lines show garbage, never the last command; the flag lines o_f keep the last flags
		{o_cla, o_ins, o_p1, o_p2, o_fid} <= ~{cla, ins, p1, p2, fid};
	endtask
	// accept after 0..2 idle cycles; the bench waits for this before the next offer
	always @(posedge i_clk) begin
		if (o_rsp_ready) begin
			o_rsp_ready <= 1'b0;
		end else if (i_rsp_valid && dly == 2'h0) begin
			o_rsp_ready <= 1'b1;
			dly <= 2'($urandom_range(2));
		end else if (i_rsp_valid) begin
			dly <= dly - 2'h1;
		end
	end
endmodule

/* tb/cca_access_ctl_tb.sv */
// testbench of the card command gate, driven through the terminal model
// assumes: cca_pkg compiled first; flag bundle f = need, fmt, df, fshr, dshr, act, usim, known, l1, l2
`timescale 1ns/1ns
module cca_access_ctl_tb;
	import cca_pkg::*;
	// ****************************************
	// clock, wiring, helpers
	// ****************************************
	localparam logic [11:0] G = 12'h064;
	logic i_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic cmd_valid, cmd_ready, rsp_valid, rsp_ready, usim, gsm, ef_valid, exec;
	logic univ = 1'b0;
	logic [7:0] cla, ins, p1, p2, rsp_data, rec_ptr, r;
	logic [15:0] fid, sw, cur_df, cur_ef;
	logic [11:0] f;
	logic [3:0] chan_open;
	logic [23:0] e;
	int error_cnt = 0;
	int num_checks = 0;
	logic [11:0] gf[6] = '{12'h062, 12'h364, 12'hc66, 12'h866, 12'h865, 12'h264};
	logic [15:0] gs[6] = '{SW_SEC, SW_SEC, SW_SEC, SW_SEC, SW_OK, SW_OK};
	logic [7:0] cp[4] = '{8'h00, 8'h04, 8'h02, 8'h02};
	logic [15:0] cs[4] = '{SW_BAD_P, SW_BAD_P, SW_OK, SW_BAD_P};
	logic [15:0] rf[3] = '{FID_CUR_APP, FID_TELECOM, FID_DIR};
	always #4 i_clk = ~i_clk;
	cca_term_model term (.i_clk(i_clk), .i_cmd_ready(cmd_ready), .i_rsp_valid(rsp_valid),
		.o_cmd_valid(cmd_valid), .o_cla(cla), .o_ins(ins), .o_p1(p1), .o_p2(p2), .o_fid(fid),
		.o_f(f), .o_rsp_ready(rsp_ready));
	cca_access_ctl dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_cmd_valid(cmd_valid),
		.o_cmd_ready(cmd_ready), .i_cla(cla), .i_ins(ins), .i_p1(p1), .i_p2(p2), .i_fid(fid),
		.i_is_df(f[7]), .i_file_shareable(f[6]), .i_cur_df_shareable(f[5]),
		.i_app_activate(f[4]), .i_app_usim(f[3]), .i_sc_need(cca_sc_e'(f[11:10])),
		.i_sc_fmt(cca_fmt_e'(f[9:8])), .i_sc_known(f[2]), .i_ver_l1(f[1]), .i_ver_l2(f[0]),
		.i_ver_univ(univ), .o_rsp_valid(rsp_valid), .i_rsp_ready(rsp_ready), .o_sw(sw),
		.o_rsp_data(rsp_data), .o_exec(exec), .o_chan_open(chan_open), .o_usim_active(usim),
		.o_gsm_active(gsm), .o_cur_df(cur_df), .o_cur_ef(cur_ef), .o_ef_valid(ef_valid),
		.o_rec_ptr(rec_ptr));
	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input string n, input logic [15:0] x, input logic [15:0] y);
		num_checks++;
		if (y !== x) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", n, x, y);
		end
	endtask
	task automatic done(input string s);
		$display("test %s done", s);
	endtask
	task automatic rst();
		@(posedge i_clk);
		i_rst_n <= 1'b0;
		repeat (10) @(posedge i_clk);
		i_rst_n <= 1'b1;
	endtask
	// one command, then a bounded wait until its answer has been compared
	task automatic run(input logic [7:0] c, i, a, b, input logic [15:0] d, input logic [11:0] g,
		input logic [15:0] s, input logic [7:0] q);
		int n;
		n = 0;
		term.cmd(c, i, a, b, d, g, s, q);
		while (term.exp_q.size() != 0 && n < 40) begin
			@(posedge i_clk);
			n++;
		end
		if (n == 40) begin
			error_cnt++;
			$display("MISMATCH response expected 1 seen 0");
			summarize();
		end
		@(negedge i_clk);
	endtask
	// each accepted response is matched against the oldest noted expectation
	always @(posedge i_clk) begin
		// the file engine may only be released on a granted command
		if (i_rst_n && exec) chk("exec_sw", SW_OK, sw);
		if (i_rst_n && rsp_valid) begin
			chk("cmd_ready", 16'h0, 16'(cmd_ready));
			if (rsp_ready) begin
				e = term.exp_q.pop_front();
				chk("sw", e[23:8], sw);
				chk("rsp_data", 16'(e[7:0]), 16'(rsp_data));
			end
		end
	end
	// ****************************************
	// scenarios
	// ****************************************
	initial begin
		void'($urandom(32'h9241c6bf));
		rst();
		chk("chan_open", 16'h1, 16'(chan_open));
		run(8'h00, INS_MANAGE, P1_OPEN, 8'h00, 16'h0, G, SW_OK, 8'h01);
		run(8'h01, INS_STATUS, 8'h00, 8'($urandom), 16'($urandom), G, SW_OK, 8'h00);
		chk("cur_df", FID_MF, cur_df);
		chk("ef_valid", 16'h0, 16'(ef_valid));
		run(8'h01, INS_SELECT, 8'h00, 8'h00, FID_TELECOM, 12'h0e4, SW_OK, 8'h00);
		run(8'h01, INS_MANAGE, P1_OPEN, 8'h00, 16'h0, G, SW_OK, 8'h02);
		run(8'h02, INS_SELECT, 8'h00, 8'h00, FID_CUR_APP, G, SW_NOT_FOUND, 8'h00);
		chk("cur_df", FID_TELECOM, cur_df);
		run(8'h00, INS_MANAGE, P1_OPEN, 8'h00, 16'h0, G, SW_OK, 8'h03);
		run(8'h00, INS_MANAGE, P1_OPEN, 8'h00, 16'h0, G, SW_NO_CHAN, 8'h00);
		chk("chan_open", 16'hf, 16'(chan_open));
		done("open");
		for (int i = 0; i < 4; i++) run(8'h00, INS_MANAGE, P1_CLOSE, cp[i], 16'h0, G, cs[i], 8'h00);
		run(8'h02, INS_STATUS, 8'h00, 8'h00, 16'h0, G, SW_CH_NS, 8'h00);
		run(8'h00, INS_MANAGE, P1_OPEN, 8'h00, 16'h0, 12'h044, SW_NOT_ALLOWED, 8'h00);
		chk("chan_open", 16'hb, 16'(chan_open));
		done("close");
		run(8'h01, INS_SELECT, P1_BY_NAME, 8'h00, 16'h0, 12'h07c, SW_OK, 8'h00);
		run(8'h03, INS_SELECT, P1_BY_NAME, 8'h00, 16'h0, 12'h07c, SW_COND, 8'h00);
		run(8'h01, INS_SELECT, 8'h00, 8'h00, FID_CUR_APP, G, SW_OK, 8'h00);
		run(CLA_GSM, INS_STATUS, 8'h00, 8'h00, 16'h0, G, SW_CLA_NS, 8'h00);
		chk("usim", 16'h1, 16'(usim));
		chk("gsm", 16'h0, 16'(gsm));
		done("session");
		run(8'h01, INS_SELECT, 8'h00, 8'h00, 16'h6f3a, 12'h024, SW_OK, 8'h00);
		chk("cur_ef", 16'h6f3a, cur_ef);
		run(8'h03, INS_SELECT, 8'h00, 8'h00, 16'h6f3a, 12'h024, SW_COND, 8'h00);
		r = 8'($urandom_range(255, 1));
		run(8'h01, INS_RDREC, r, 8'h04, 16'h0, 12'h466, SW_OK, 8'h00);
		chk("rec_ptr", 16'(r), 16'(rec_ptr));
		run(8'h01, INS_RDREC, REC_NEXT, 8'h04, 16'h0, 12'h466, SW_OK, 8'h00);
		chk("rec_ptr", 16'(8'(r + 8'h01)), 16'(rec_ptr));
		run(8'h03, INS_STATUS, 8'h00, 8'h00, 16'h0, G, SW_OK, 8'h00);
		chk("rec_ptr", 16'h0, 16'(rec_ptr));
		done("files");
		for (int i = 0; i < 6; i++) run(8'h01, INS_UPREC, 8'h01, 8'h04, 16'h0, gf[i], gs[i], 8'h00);
		run(8'h01, INS_STATUS, 8'h00, 8'h00, 16'h0, 12'h060, SW_OK, 8'h00);
		// universal code stands in for a missing level-1 code on a multi card
		@(posedge i_clk) univ <= 1'b1;
		run(8'h01, INS_UPREC, 8'h01, 8'h04, 16'h0, 12'h464, SW_OK, 8'h00);
		@(posedge i_clk) univ <= 1'b0;
		for (int i = 0; i < 3; i++) run(8'h01, INS_CREATE, 8'h00, 8'h00, rf[i], G, SW_EXISTS, 8'h00);
		done("gate");
		rst();
		run(CLA_GSM, INS_STATUS, 8'h00, 8'h00, 16'h0, G, SW_OK, 8'h00);
		chk("gsm", 16'h1, 16'(gsm));
		run(8'h00, INS_SELECT, P1_BY_NAME, 8'h00, 16'h0, 12'h07c, SW_COND, 8'h00);
		chk("usim", 16'h0, 16'(usim));
		done("legacy");
		summarize();
	end
endmodule
